// [shr_shift_register.v]
// Five-stage shift register with clear, preset and serial shift
`timescale 1ns/1ps
`include "shr_defines.vh"
module shr_shift_register #(
  parameter STAGES = `SHR_STAGES
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins from the driving logic
  input wire shift_clk,
  input wire zero_all_n,
  input wire load_gate,
  input wire serial_in,
  input wire [STAGES-1:0] load_value,
  // Stage outputs
  output wire [STAGES-1:0] stage_out
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  // All pins share one delay, so serial data stays aligned with its clock edge
  wire [STAGES+3:0] sync_lvl;
  wire shift_clk_s;
  wire zero_all_n_s;
  wire load_gate_s;
  wire serial_in_s;
  wire [STAGES-1:0] load_value_s;

  shr_sync #(
    .W(STAGES + 4),
    .RST_VAL(`SHR_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({shift_clk, zero_all_n, load_gate, serial_in, load_value}),
    .sync_out(sync_lvl)
  );

  assign shift_clk_s = sync_lvl[STAGES+3];
  assign zero_all_n_s = sync_lvl[STAGES+2];
  assign load_gate_s = sync_lvl[STAGES+1];
  assign serial_in_s = sync_lvl[STAGES];
  assign load_value_s = sync_lvl[STAGES-1:0];

  // ****************************************
  // Rising edge of the shift clock
  // ****************************************
  // Three arming states stop a shift_clk held high through reset from
  // looking like an edge
  localparam [4:0] ST_ARM0 = 5'h01;
  localparam [4:0] ST_ARM1 = 5'h02;
  localparam [4:0] ST_ARM2 = 5'h04;
  localparam [4:0] ST_LOW = 5'h08;
  localparam [4:0] ST_HIGH = 5'h10;

  reg [4:0] edge_st_ff;
  reg [4:0] nxt_edge_st;
  reg shift_rise;

  // Tracker state that matches a synchronised level
  function [4:0] level_state;
    input lvl;
    begin
      if (lvl) begin
        level_state = ST_HIGH;
      end else begin
        level_state = ST_LOW;
      end
    end
  endfunction

  always @* begin
    nxt_edge_st = edge_st_ff;
    shift_rise = 1'h0;
    case (edge_st_ff)
      ST_ARM0: begin
        nxt_edge_st = ST_ARM1;
      end
      ST_ARM1: begin
        nxt_edge_st = ST_ARM2;
      end
      ST_ARM2: begin
        // Third edge takes up the current level without shifting
        nxt_edge_st = level_state(shift_clk_s);
      end
      ST_LOW: begin
        shift_rise = shift_clk_s;
        nxt_edge_st = level_state(shift_clk_s);
      end
      ST_HIGH: begin
        // A falling level only returns to ST_LOW, it never shifts
        nxt_edge_st = level_state(shift_clk_s);
      end
      default: begin
        nxt_edge_st = ST_ARM0;
      end
    endcase
  end

  // ****************************************
  // Tracker state register
  // ****************************************
  // Reset lands in the first arming state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_st_ff <= ST_ARM0;
    end else begin
      edge_st_ff <= nxt_edge_st;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  localparam [3:0] MODE_HOLD = 4'h1;
  localparam [3:0] MODE_SHIFT = 4'h2;
  localparam [3:0] MODE_PRESET = 4'h4;
  localparam [3:0] MODE_CLEAR = 4'h8;

  // Clear first: preset with clear is undefined, so clear is the safe choice
  function [3:0] pick_mode;
    input clr_n;
    input gate;
    input rise;
    begin
      if (!clr_n) begin
        pick_mode = MODE_CLEAR;
      end else if (gate) begin
        // Clock ignored while the gate is open
        pick_mode = MODE_PRESET;
      end else if (rise) begin
        pick_mode = MODE_SHIFT;
      end else begin
        pick_mode = MODE_HOLD;
      end
    end
  endfunction

  // Exactly one mode bit is set in every cycle
  wire [3:0] mode;
  assign mode = pick_mode(zero_all_n_s, load_gate_s, shift_rise);

  // ****************************************
  // Stages
  // ****************************************
  reg [STAGES-1:0] stage_ff;
  wire [STAGES-1:0] nxt_stage;

  // Next content of one stage for the decoded mode
  function next_bit;
    input [3:0] md;
    input cur;
    input pre;
    input sh;
    begin
      case (md)
        MODE_CLEAR: begin
          next_bit = `SHR_CLEAR_BIT;
        end
        MODE_PRESET: begin
          next_bit = pre;
        end
        MODE_SHIFT: begin
          next_bit = sh;
        end
        MODE_HOLD: begin
          next_bit = cur;
        end
        default: begin
          next_bit = cur;
        end
      endcase
    end
  endfunction

  // ****************************************
  // Shift path
  // ****************************************
  wire [STAGES-1:0] shifted;

  // Stage 0 takes the serial input, the rest take their predecessor
  // The last stage drops out on each shift
  assign shifted[0] = serial_in_s;
  genvar i;
  generate
    for (i = 1; i < STAGES; i = i + 1) begin : g_chain
      assign shifted[i] = stage_ff[i-1];
    end
  endgenerate

  // ****************************************
  // Next stage values
  // ****************************************
  // Each stage picks its own load_value bit, so any set can be preset at once
  genvar j;
  generate
    for (j = 0; j < STAGES; j = j + 1) begin : g_next
      assign nxt_stage[j] = next_bit(mode, stage_ff[j], load_value_s[j], shifted[j]);
    end
  endgenerate

  // ****************************************
  // Stage register
  // ****************************************
  // All decoding sits in nxt_stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_ff <= `SHR_STAGE_RST;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign stage_out = stage_ff;
endmodule

// [shr_defines.vh]
// Constants for the five-stage shift register
`ifndef SHR_DEFINES_VH
`define SHR_DEFINES_VH

// ****************************************
// Sizes and reset values
// ****************************************
`define SHR_STAGES 5
`define SHR_STAGE_RST 5'h00
`define SHR_SYNC_RST 9'h000
`define SHR_CLEAR_BIT 1'h0

`endif

// [shr_sync.v]
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module shr_sync #(
  parameter W = 9,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins and synchronised levels
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // Only the second flop reads the first
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// [shr_monitor.sv]
// Pin-level checks for the shift register
`timescale 1ns/1ps
module shr_monitor #(parameter STAGES = 5) (
  input logic clk,
  input logic rst,
  input logic shift_clk,
  input logic zero_all_n,
  input logic load_gate,
  input logic serial_in,
  input logic [STAGES-1:0] load_value,
  input logic [STAGES-1:0] stage_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pins land in the stages three edges later
  wire run = zero_all_n & ~load_gate;
  wire pre = zero_all_n & load_gate;
  sequence s_edge; run && $rose(shift_clk); endsequence
  property p_clr; !zero_all_n |-> ##3 stage_out == '0; endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_pre; pre |-> ##3 stage_out == $past(load_value, 3); endproperty
  a_pre: assert property (p_pre) else $error("preset missed");
  property p_sel; pre |-> ##3 (stage_out & ~$past(load_value, 3)) == '0; endproperty
  a_sel: assert property (p_sel) else $error("extra stage set");
  property p_pclk; pre && $rose(shift_clk) |-> ##3 stage_out == $past(load_value, 3); endproperty
  a_pclk: assert property (p_pclk) else $error("preset upset by clock");
  property p_shf; s_edge |-> ##3 stage_out == {$past(stage_out[STAGES-2:0]), $past(serial_in, 3)}; endproperty
  a_shf: assert property (p_shf) else $error("bad shift");
  property p_last; s_edge |-> ##3 stage_out[STAGES-1] == $past(stage_out[STAGES-2]); endproperty
  a_last: assert property (p_last) else $error("serial out wrong");
  property p_fall; run && $fell(shift_clk) |-> ##3 $stable(stage_out); endproperty
  a_fall: assert property (p_fall) else $error("falling edge moved");
  property p_hold; run && !$rose(shift_clk) |-> ##3 $stable(stage_out); endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
endmodule

// [shr_host.sv]
// Driving logic around the shift register
`timescale 1ns/1ps
module shr_host (
  input logic clk,
  output logic shift_clk,
  output logic zero_all_n,
  output logic load_gate,
  output logic serial_in,
  output logic [4:0] load_value
);
  initial begin
    shift_clk = 1'b0;
    zero_all_n = 1'b1;
    load_gate = 1'b0;
    serial_in = 1'b0;
    load_value = 5'h00;
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task shift(input logic d);
    serial_in = d;
    wt(2);
    shift_clk = 1'b1;
    wt(3);
    shift_clk = 1'b0;
    wt(4);
  endtask
  // Clock rises inside the gate and falls after it
  task load(input logic [4:0] v);
    load_value = v;
    load_gate = 1'b1;
    wt(2);
    shift_clk = 1'b1;
    wt(4);
    load_gate = 1'b0;
    wt(4);
    shift_clk = 1'b0;
    wt(4);
  endtask
  task clear;
    zero_all_n = 1'b0;
    wt(6);
    zero_all_n = 1'b1;
    wt(4);
  endtask
endmodule

// [tb_shr_shift_register.sv]
// Self-checking bench for the shift register
`timescale 1ns/1ps
module tb_shr_shift_register;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic shift_clk, zero_all_n, load_gate, serial_in;
  logic [4:0] load_value, stage_out;
  int fails = 0;
  int check_count = 0;
  initial forever #2 clk = ~clk;
  shr_host u_host(.clk(clk), .shift_clk(shift_clk), .zero_all_n(zero_all_n), .load_gate(load_gate),
    .serial_in(serial_in), .load_value(load_value));
  shr_shift_register #(.STAGES(5)) DUT(.clk(clk), .rst(rst), .shift_clk(shift_clk), .zero_all_n(zero_all_n),
    .load_gate(load_gate), .serial_in(serial_in), .load_value(load_value), .stage_out(stage_out));
  task cmp(input logic [4:0] got, input logic [4:0] want);
    check_count++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task t_load;
    u_host.load(5'h1f);
    cmp(stage_out, 5'h1f);
    u_host.load(5'h04);
    cmp(stage_out, 5'h04);
    u_host.load(5'h1a);
    cmp(stage_out, 5'h1a);
    $display("preset test done");
  endtask
  task t_clear;
    u_host.clear;
    cmp(stage_out, 5'h00);
    $display("clear test done");
  endtask
  task t_shift;
    logic [7:0] pat;
    logic [4:0] want;
    pat = 8'hb5;
    want = 5'h00;
    for (int i = 0; i < 8; i++) begin
      u_host.shift(pat[i]);
      want = {want[3:0], pat[i]};
      cmp(stage_out, want);
    end
    repeat (20) @(posedge clk);
    #1;
    cmp(stage_out, want);
    $display("shift test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #4000;
    fails++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    t_load;
    t_clear;
    t_shift;
    final_report;
  end
endmodule
bind shr_shift_register shr_monitor #(.STAGES(STAGES)) u_mon(.clk(clk), .rst(rst), .shift_clk(shift_clk),
  .zero_all_n(zero_all_n), .load_gate(load_gate), .serial_in(serial_in), .load_value(load_value), .stage_out(stage_out));
